// ===== rtl/lsr_cfg.svh
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH
`define LSR_STAGES     16
`define LSR_TAP_W      4
`define LSR_LAST_STAGE 15
`define LSR_TABLES     4
`define LSR_SEL_W      6
`define LSR_DEPTH      64
`endif

// ===== rtl/lsr_pkg.sv
package lsr_pkg;
	typedef logic [15:0] lsr_stage_t;
	typedef logic [3:0]  lsr_tap_t;
	typedef logic [5:0]  lsr_sel_t;
endpackage

// ===== rtl/lsr_table.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsr_cfg.svh"
// one table used as a 16-stage enabled shift register
module lsr_table (
	input  wire logic              clk_sys,
	input  wire logic              shift_en,
	input  wire logic              shift_in,
	input  wire lsr_pkg::lsr_tap_t tap_sel,
	output logic                   tap_out,
	output logic                   last_stage_output
);
	lsr_pkg::lsr_stage_t stage_q;
	lsr_pkg::lsr_stage_t stage_d;

	// no reset: contents only change by shifting
	always_comb begin
		stage_d = stage_q;
		if (shift_en) begin
			stage_d = {stage_q[`LSR_STAGES-2:0], shift_in}; // [RL1] [RL10]
		end
	end

	always_ff @(posedge clk_sys) begin
		stage_q <= stage_d; // [RL11]
	end

	assign tap_out           = stage_q[tap_sel];              // [RL3] [RL13]
	assign last_stage_output = stage_q[`LSR_LAST_STAGE];      // [RL4]
endmodule
`default_nettype wire

// ===== rtl/lsr_cluster.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsr_cfg.svh"
// Behaviour
// [RL1] each table is a 16-stage shift register held in table storage.
// [RL2] one table delays serial data by 1 to 16 cycles.
// [RL3] a 4-bit tap select picks the stage shown on the addressable output.
// [RL4] each table has a last-stage output always carrying stage 15.
// [RL5] the upper table feeds the lower table through an intra-slice cascade mux.
// [RL6] each slice has a chain output and the next slice a chain input.
// [RL7] four tables chain into up to 64 cycles, and clusters chain onward.
// [RL8] a following flip-flop can register the tap, adding exactly one cycle.
// [RL9] the variant has both the cascade output and a clock enable.
// [RL10] stages shift on each rising edge with enable high, else hold.
// [RL11] stored stages have no preset or reset.
// [RL12] one clock and one enable are shared by a slice; unused enable reads active.
// [RL13] the addressable output follows tap select without a clock edge.
module lsr_cluster (
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	input  wire logic              data_in,
	input  wire logic              chain_input,
	input  wire logic              use_chain_input,
	input  wire logic              shift_en_n,
	input  wire lsr_pkg::lsr_sel_t delay_sel,
	output logic                   tap_out,
	output logic                   tap_reg_q,
	output logic                   chain_output
);
	// active-low enable: an unconnected pin pulled low keeps shifting
	logic                   shift_en;
	logic [`LSR_TABLES:0]   link;
	logic [`LSR_TABLES-1:0] taps;
	logic [`LSR_TABLES-1:0] lasts;
	logic                   sel_tap;
	logic                   tap_reg_d;
	logic [1:0]             tab_idx;
	lsr_pkg::lsr_tap_t      tap_idx;
	logic [6:0]             fill_q;
	logic [6:0]             fill_d;
	logic                   fill_full;

	// table index: upper two bits of the delay select
	function automatic logic [1:0] tab_of(input lsr_pkg::lsr_sel_t sel);
		tab_of = sel[`LSR_SEL_W-1:`LSR_TAP_W];
	endfunction

	// stage index inside one table: lower four bits
	function automatic lsr_pkg::lsr_tap_t tap_of(input lsr_pkg::lsr_sel_t sel);
		tap_of = sel[`LSR_TAP_W-1:0];
	endfunction

	assign shift_en = ~shift_en_n; // [RL12]
	assign tab_idx  = tab_of(delay_sel);
	assign tap_idx  = tap_of(delay_sel);

	// fabric data or chain from the cluster above
	assign link[0] = use_chain_input ? chain_input : data_in; // [RL5] [RL6]

	// slice 0, upper table
	lsr_table tab_s0_upper (
		.clk_sys           (clk_sys),
		.shift_en          (shift_en),
		.shift_in          (link[0]),
		.tap_sel           (tap_idx),
		.tap_out           (taps[0]),
		.last_stage_output (lasts[0])
	);

	// intra-slice cascade mux: upper last stage feeds the lower table
	assign link[1] = lasts[0]; // [RL5] [RL9]

	// slice 0, lower table; clock and enable shared with the upper one
	lsr_table tab_s0_lower (
		.clk_sys           (clk_sys),
		.shift_en          (shift_en),
		.shift_in          (link[1]),
		.tap_sel           (tap_idx),
		.tap_out           (taps[1]),
		.last_stage_output (lasts[1])
	);

	// chain output of slice 0 runs into the chain input of slice 1
	assign link[2] = lasts[1]; // [RL6] [RL7]

	// slice 1, upper table
	lsr_table tab_s1_upper (
		.clk_sys           (clk_sys),
		.shift_en          (shift_en),
		.shift_in          (link[2]),
		.tap_sel           (tap_idx),
		.tap_out           (taps[2]),
		.last_stage_output (lasts[2])
	);

	assign link[3] = lasts[2]; // [RL5] [RL9]

	// slice 1, lower table
	lsr_table tab_s1_lower (
		.clk_sys           (clk_sys),
		.shift_en          (shift_en),
		.shift_in          (link[3]),
		.tap_sel           (tap_idx),
		.tap_out           (taps[3]),
		.last_stage_output (lasts[3])
	);

	// last stage of the cluster goes on to the next cluster
	assign link[4] = lasts[3]; // [RL6] [RL7] [RL9]

	// upper bits choose the table: delay = 16*table + tap + 1, up to 64
	always_comb begin
		case (tab_idx) // [RL2] [RL7]
			2'h0: begin
				sel_tap = taps[0];
			end
			2'h1: begin
				sel_tap = taps[1];
			end
			2'h2: begin
				sel_tap = taps[2];
			end
			2'h3: begin
				sel_tap = taps[3];
			end
			default: begin
				sel_tap = taps[0];
			end
		endcase
	end

	assign tap_out      = sel_tap;            // [RL13]
	assign chain_output = link[`LSR_TABLES]; // [RL6]

	always_comb begin
		tap_reg_d = sel_tap; // [RL8]
	end

	// cluster flip-flop and the fill counter are the only elements with a reset
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tap_reg_q <= 1'b0;
		end else begin
			tap_reg_q <= tap_reg_d;
		end
	end

	// stages are never cleared, so checks wait until all 64 hold shifted data
	always_comb begin
		fill_d = fill_q;
		if (shift_en && !fill_full) begin
			fill_d = 7'(fill_q + 7'h01);
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fill_q <= 7'h00;
		end else begin
			fill_q <= fill_d;
		end
	end

	assign fill_full = (fill_q == 7'(`LSR_DEPTH));

	a_tap_reg_delay: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL8]
		fill_full && $past(fill_full) |-> tap_reg_q == $past(sel_tap))
		else $error("registered tap mismatch");

	a_hold_no_en: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL10]
		fill_full && $past(shift_en_n) && $stable(delay_sel) |-> $stable(tap_out))
		else $error("tap changed while disabled");

	a_reg_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL8]
		fill_full && $past(shift_en_n) && $stable(delay_sel) |-> tap_reg_q == tap_out)
		else $error("registered tap differs while held");

	a_chain_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL11]
		fill_full && $past(shift_en_n) |-> $stable(chain_output))
		else $error("chain output moved without shift");

	a_first_stage: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL2]
		fill_full && !shift_en_n |=> tab_of(delay_sel) != 2'h0
			|| tap_of(delay_sel) != 4'h0 || tap_out == $past(link[0]))
		else $error("first stage does not hold the last input");

	a_chain_last: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL4]
		fill_full && !shift_en_n && delay_sel == 6'h3E |=> chain_output == $past(sel_tap))
		else $error("chain output wrong");

	a_table_edge: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL7]
		fill_full && !shift_en_n && tap_of(delay_sel) == 4'hF && tab_of(delay_sel) != 2'h3
		##1 tap_of(delay_sel) == 4'h0
		&& tab_of(delay_sel) == 2'(tab_of($past(delay_sel)) + 2'h1)
		|-> sel_tap == $past(sel_tap))
		else $error("table cascade lost a bit");
endmodule
`default_nettype wire

// ===== verif/lsr_fab.sv
`timescale 1ns/1ps
`default_nettype none
// fabric side: pattern on data, inverse on chain, history of shifted bits
module lsr_fab (
	input  wire logic  clk_sys,
	input  wire logic  shift_en_n,
	input  wire logic  use_chain_input,
	output logic       data_in,
	output logic       chain_input,
	output logic [63:0] hist
);
	logic [7:0] cnt = 8'h00;
	assign chain_input = ~data_in;
	always @(negedge clk_sys) begin
		cnt <= cnt + 8'h01;
		data_in <= cnt[0] ^ cnt[3] ^ cnt[5];
	end
	always @(posedge clk_sys) if (!shift_en_n) hist <= {hist[62:0], use_chain_input ? chain_input : data_in};
endmodule
`default_nettype wire

// ===== verif/lsr_cluster_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lsr_cluster_tb;
	logic clk_sys = 1'b0, rstn = 1'b0, use_chain_input = 1'b0, shift_en_n = 1'b0;
	logic data_in, chain_input, tap_out, tap_reg_q, chain_output;
	logic [63:0] hist;
	lsr_pkg::lsr_sel_t delay_sel = 6'h3F;
	int err_total = 0, checks_done = 0;
	always #25 clk_sys = ~clk_sys;
	lsr_fab lsr_fab_inst (.clk_sys, .shift_en_n, .use_chain_input, .data_in, .chain_input, .hist);
	lsr_cluster lsr_cluster_inst (.clk_sys, .rstn, .data_in, .chain_input, .use_chain_input,
		.shift_en_n, .delay_sel, .tap_out, .tap_reg_q, .chain_output);
	task chk(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t sel %0d got %b", $time, delay_sel, got);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task t_taps;
		for (int s = 0; s < 64; s++) begin
			delay_sel = s[5:0];
			@(negedge clk_sys);
			chk(tap_out, hist[s]);
			if (s < 63) chk(tap_reg_q, hist[s + 1]);
			chk(chain_output, hist[63]);
		end
		$display("taps done");
	endtask
	task t_hold;
		shift_en_n = 1'b1;
		for (int s = 0; s < 64; s += 7) begin
			delay_sel = s[5:0];
			#1 chk(tap_out, hist[s]);
			@(negedge clk_sys);
			chk(tap_out, hist[s]);
			@(negedge clk_sys);
			chk(tap_out, hist[s]);
			chk(tap_reg_q, hist[s]);
			chk(chain_output, hist[63]);
		end
		shift_en_n = 1'b0;
		$display("hold done");
	endtask
	task t_chain;
		use_chain_input = 1'b1;
		repeat (70) @(negedge clk_sys);
		t_taps();
		$display("chain done");
	endtask
	initial begin
		repeat (6) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (70) @(negedge clk_sys);
		t_taps();
		t_hold();
		t_chain();
		test_done();
	end
	// run needs about 300 cycles; allow generous margin
	initial begin
		#40000;
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire
